// ===== hdl/pscs_pkg.sv
// Package with opcode, width and reset constants for the port set and compare skip unit
package pscs_pkg;
  localparam int PSCS_NIB_W = 4;
  localparam int PSCS_PC_W = 4;
  localparam int PSCS_PD_W = 6;
  localparam int PSCS_DP_W = 6;
  localparam int PSCS_OP_W = 10;
  localparam logic [PSCS_OP_W-1:0] PSCS_OP_SET_C = 10'h28D;
  localparam logic [PSCS_OP_W-1:0] PSCS_OP_SET_D = 10'h015;
  localparam logic [PSCS_OP_W-1:0] PSCS_OP_SKIP_IMM = 10'h025;
  localparam logic [PSCS_OP_W-1:0] PSCS_OP_SKIP_MEM = 10'h026;
  localparam logic [PSCS_PD_W-1:0] PSCS_PD_LAST = 6'h05;
  localparam logic [PSCS_NIB_W-1:0] PSCS_Y_MAX = 4'h5;
  localparam logic [PSCS_PC_W-1:0] PSCS_PC_ALL = 4'hF;
  localparam logic [PSCS_PC_W-1:0] PSCS_PC_RST = 4'h0;
  localparam logic [PSCS_PD_W-1:0] PSCS_PD_RST = 6'h00;
  localparam logic [PSCS_PD_W-1:0] PSCS_PD_ONE = 6'h01;
  typedef enum logic [0:0] {PSCS_ST_FETCH, PSCS_ST_OPERAND} pscs_state_e;
endpackage

// ===== hdl/pscs_unit.sv
// Execution unit for port set and accumulator compare-and-skip instructions
// Functional notes
// [RULE1] Whole port C set drives all C latch lines high; one word, one cycle, no skip.
// [RULE2] Indexed port D set raises only line equal to index 0 to 5; no skip.
// [RULE3] Index above 5 makes indexed port D set a no-operation.
// [RULE4] Immediate compare of accumulator: two words, two cycles, skip when equal.
// [RULE5] Immediate compare unequal: no skip, next instruction runs normally.
// [RULE6] Memory compare reads nibble at data pointer; skip next when equal.
// [RULE7] Memory compare unequal: no skip, next instruction runs.
// [RULE8] No carry, accumulator, index or pointer change; skipped word still uses fetch cycle.
`timescale 1ns/1ps
module pscs_unit
  import pscs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic instr_valid_in,
  input wire logic [PSCS_OP_W-1:0] instr_word_in,
  input wire logic [PSCS_NIB_W-1:0] acc_in,
  input wire logic [PSCS_NIB_W-1:0] index_reg_in,
  input wire logic [PSCS_DP_W-1:0] data_pointer_in,
  input wire logic [PSCS_NIB_W-1:0] addressed_memory_nibble_in,
  output logic [PSCS_DP_W-1:0] mem_addr_out,
  output logic [PSCS_PC_W-1:0] port_c_out,
  output logic [PSCS_PD_W-1:0] port_d_out,
  output logic skip_out,
  output logic discard_out,
  output logic busy_out
);
  // Sequencer state
  pscs_state_e state_ff;
  pscs_state_e nxt_state;

  // Port latches
  logic [PSCS_PC_W-1:0] port_c_ff;
  wire logic [PSCS_PC_W-1:0] nxt_port_c;
  logic [PSCS_PD_W-1:0] port_d_ff;
  wire logic [PSCS_PD_W-1:0] nxt_port_d;

  // Skip and discard flags
  logic skip_ff;
  logic nxt_skip;
  logic discard_ff;
  logic nxt_discard;

  // Busy and address registers
  logic busy_ff;
  logic nxt_busy;
  logic [PSCS_DP_W-1:0] mem_addr_ff;
  logic [PSCS_DP_W-1:0] nxt_mem_addr;

  // Word qualification
  wire logic in_fetch = (state_ff == PSCS_ST_FETCH);
  wire logic in_operand = (state_ff == PSCS_ST_OPERAND);
  wire logic word_live = instr_valid_in && !discard_ff;
  wire logic exec = word_live && in_fetch;
  wire logic operand_now = instr_valid_in && in_operand;

  // Opcode decode
  wire logic op_set_c = (instr_word_in == PSCS_OP_SET_C);
  wire logic op_set_d = (instr_word_in == PSCS_OP_SET_D);
  wire logic op_skip_imm = (instr_word_in == PSCS_OP_SKIP_IMM);
  wire logic op_skip_mem = (instr_word_in == PSCS_OP_SKIP_MEM);
  wire logic is_set_c = exec && op_set_c;
  wire logic is_set_d = exec && op_set_d;
  wire logic is_skip_imm = exec && op_skip_imm;
  wire logic is_skip_mem = exec && op_skip_mem;

  // Operand field
  wire logic [PSCS_NIB_W-1:0] imm_nibble = instr_word_in[PSCS_NIB_W-1:0];

  // [RULE3] Index range check
  wire logic index_ok = (index_reg_in <= PSCS_Y_MAX);
  wire logic d_write = is_set_d && index_ok;

  // [RULE4] Immediate operand compare
  wire logic imm_equal = (acc_in == imm_nibble);
  // [RULE5] Skip only on equality
  wire logic imm_skip = operand_now && imm_equal;

  // [RULE6] Memory nibble compare
  wire logic mem_equal = (acc_in == addressed_memory_nibble_in);
  // [RULE7] No skip when unequal
  wire logic mem_skip = is_skip_mem && mem_equal;

  // [RULE1] Every port C line high
  generate
    for (genvar j = 0; j < PSCS_PC_W; j++) begin : g_port_c
      assign nxt_port_c[j] = is_set_c ? PSCS_PC_ALL[j] : port_c_ff[j];
    end
  endgenerate

  // [RULE2] One line per index
  generate
    for (genvar i = 0; i < PSCS_PD_W; i++) begin : g_port_d
      wire logic line_hit = d_write && (index_reg_in == PSCS_NIB_W'(i));
      assign nxt_port_d[i] = line_hit ? 1'b1 : port_d_ff[i];
    end
  endgenerate

  // [RULE4] Second word cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PSCS_ST_FETCH: begin
        if (is_skip_imm) begin
          nxt_state = PSCS_ST_OPERAND;
        end
      end
      PSCS_ST_OPERAND: begin
        if (instr_valid_in) begin
          nxt_state = PSCS_ST_FETCH;
        end
      end
      default: begin
        nxt_state = PSCS_ST_FETCH;
      end
    endcase
  end

  // Busy follows next state
  assign nxt_busy = (nxt_state == PSCS_ST_OPERAND);

  // Skip pulse per phase
  always_comb begin
    nxt_skip = 1'b0;
    case (state_ff)
      PSCS_ST_FETCH: begin
        nxt_skip = mem_skip;
      end
      PSCS_ST_OPERAND: begin
        nxt_skip = imm_skip;
      end
      default: begin
        nxt_skip = 1'b0;
      end
    endcase
  end

  // [RULE8] Skipped word consumes fetch
  always_comb begin
    nxt_discard = discard_ff;
    case (state_ff)
      PSCS_ST_FETCH: begin
        if (instr_valid_in) begin
          nxt_discard = nxt_skip;
        end
      end
      PSCS_ST_OPERAND: begin
        if (instr_valid_in) begin
          nxt_discard = nxt_skip;
        end
      end
      default: begin
        nxt_discard = 1'b0;
      end
    endcase
  end

  // Address follows data pointer
  assign nxt_mem_addr = data_pointer_in;

  // Register updates
  // [RULE4] Sequencer register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= PSCS_ST_FETCH;
    end else if (clk_en_in) begin
      state_ff <= nxt_state;
    end
  end

  // [RULE4] Busy register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_ff <= 1'b0;
    end else if (clk_en_in) begin
      busy_ff <= nxt_busy;
    end
  end

  // [RULE1] Port C latch
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_c_ff <= PSCS_PC_RST;
    end else if (clk_en_in) begin
      port_c_ff <= nxt_port_c;
    end
  end

  // [RULE2] Port D latch
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_d_ff <= PSCS_PD_RST;
    end else if (clk_en_in) begin
      port_d_ff <= nxt_port_d;
    end
  end

  // [RULE6] Skip pulse register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      skip_ff <= 1'b0;
    end else if (clk_en_in) begin
      skip_ff <= nxt_skip;
    end
  end

  // [RULE8] Discard register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      discard_ff <= 1'b0;
    end else if (clk_en_in) begin
      discard_ff <= nxt_discard;
    end
  end

  // [RULE6] Memory address register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_addr_ff <= '0;
    end else if (clk_en_in) begin
      mem_addr_ff <= nxt_mem_addr;
    end
  end

  // Outputs straight from flops
  assign mem_addr_out = mem_addr_ff;
  assign port_c_out = port_c_ff;
  assign port_d_out = port_d_ff;
  assign skip_out = skip_ff;
  assign discard_out = discard_ff;
  assign busy_out = busy_ff;
endmodule

// ===== tb/pscs_unit_assertions.sv
// Checker for the port set and compare skip unit
`timescale 1ns/1ps
module pscs_chk
  import pscs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic instr_valid_in,
  input wire logic [PSCS_OP_W-1:0] instr_word_in,
  input wire logic [PSCS_NIB_W-1:0] acc_in,
  input wire logic [PSCS_NIB_W-1:0] index_reg_in,
  input wire logic [PSCS_NIB_W-1:0] addressed_memory_nibble_in,
  input wire logic [PSCS_PC_W-1:0] port_c_out,
  input wire logic [PSCS_PD_W-1:0] port_d_out,
  input wire logic skip_out,
  input wire logic discard_out,
  input wire logic busy_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire v = clk_en_in && instr_valid_in;
  wire t = v && !discard_out && !busy_out;
  wire [PSCS_OP_W-1:0] w = instr_word_in;
  wire eq = w[3:0] == acc_in;
  wire me = addressed_memory_nibble_in == acc_in;
  wire d = t && w == PSCS_OP_SET_D;
  a_port_c_set: assert property (t && w == PSCS_OP_SET_C |=> port_c_out == PSCS_PC_ALL) else $error("c");
  a_line_d_set: assert property (d && index_reg_in <= PSCS_Y_MAX |=>
    port_d_out == ($past(port_d_out) | (PSCS_PD_ONE << $past(index_reg_in)))) else $error("d");
  a_line_d_nop: assert property (d && index_reg_in > PSCS_Y_MAX |=> $stable(port_d_out) && !skip_out) else $error("nop");
  a_imm_eq: assert property (busy_out && v && eq |=> skip_out && discard_out) else $error("imm");
  a_imm_ne: assert property (busy_out && v && !eq |=> !skip_out) else $error("imm ne");
  a_mem_eq: assert property (t && w == PSCS_OP_SKIP_MEM && me |=> skip_out) else $error("mem");
  a_mem_ne: assert property (t && w == PSCS_OP_SKIP_MEM && !me |=> !skip_out && !discard_out) else $error("mem ne");
  a_drop_word: assert property (discard_out && v |=> $stable(port_d_out) && !discard_out) else $error("drop");
  cover property (skip_out);
  cover property (busy_out);
  cover property (port_d_out == 6'h3F);
endmodule
bind pscs_unit pscs_chk chk (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .clk_en_in(clk_en_in),
  .instr_valid_in(instr_valid_in),
  .instr_word_in(instr_word_in),
  .acc_in(acc_in),
  .index_reg_in(index_reg_in),
  .addressed_memory_nibble_in(addressed_memory_nibble_in),
  .port_c_out(port_c_out),
  .port_d_out(port_d_out),
  .skip_out(skip_out),
  .discard_out(discard_out),
  .busy_out(busy_out)
);

// ===== tb/tb_top.sv
// Testbench for the port set and compare skip unit
`timescale 1ns/1ps
module tb_top;
  import pscs_pkg::*;
  logic sys_clk_in = 0, rst_in = 1, clk_en_in = 1, instr_valid_in = 0, skip_out, discard_out, busy_out;
  logic [PSCS_OP_W-1:0] instr_word_in = 10'h000;
  logic [PSCS_NIB_W-1:0] acc_in = 4'h0, index_reg_in = 4'h0, addressed_memory_nibble_in = 4'h0;
  logic [PSCS_DP_W-1:0] data_pointer_in = 6'h2A, mem_addr_out;
  logic [PSCS_PC_W-1:0] port_c_out;
  logic [PSCS_PD_W-1:0] port_d_out, e = 6'h00;
  int errors = 0, n_tests = 0;
  pscs_unit uut (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .instr_valid_in(instr_valid_in),
    .instr_word_in(instr_word_in),
    .acc_in(acc_in),
    .index_reg_in(index_reg_in),
    .data_pointer_in(data_pointer_in),
    .addressed_memory_nibble_in(addressed_memory_nibble_in),
    .mem_addr_out(mem_addr_out),
    .port_c_out(port_c_out),
    .port_d_out(port_d_out),
    .skip_out(skip_out),
    .discard_out(discard_out),
    .busy_out(busy_out)
  );
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  task chk(input logic [7:0] g, x);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task put(input logic [PSCS_OP_W-1:0] op);
    instr_word_in = op;
    instr_valid_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
  endtask
  task s_c;
    put(PSCS_OP_SET_C);
    chk(port_c_out, PSCS_PC_ALL);
    chk(mem_addr_out, 6'h2A);
  endtask
  task s_cmp(input logic m, input logic [3:0] n);
    acc_in = 4'h7;
    addressed_memory_nibble_in = n;
    put(m ? PSCS_OP_SKIP_MEM : PSCS_OP_SKIP_IMM);
    if (!m) chk(busy_out, 1'b1);
    if (!m) put({6'h00, n});
    chk(skip_out, n == 4'h7);
    chk(discard_out, n == 4'h7);
    index_reg_in = {3'h0, m};
    put(PSCS_OP_SET_D);
    if (n != 4'h7) e[m] = 1'b1;
    chk(port_d_out, e);
    chk(discard_out, 1'b0);
    chk(skip_out, 1'b0);
  endtask
  task s_f;
    clk_en_in = 1'b0;
    index_reg_in = 4'h2;
    put(PSCS_OP_SET_D);
    chk(port_d_out, e);
    clk_en_in = 1'b1;
  endtask
  task s_r;
    rst_in = 1'b1;
    @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
    e = 6'h00;
    chk(port_c_out, PSCS_PC_RST);
    chk(port_d_out, e);
    s_c;
  endtask
  task s_d;
    for (int i = 0; i < 8; i++) begin
      index_reg_in = i[3:0];
      put(PSCS_OP_SET_D);
      if (i < 6) e[i] = 1'b1;
      chk(port_d_out, e);
    end
  endtask
  task test_done;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_in);
    #1 rst_in = 0;
    s_c;
    s_cmp(0, 4'h7);
    s_cmp(0, 4'h3);
    s_cmp(1, 4'h7);
    s_cmp(1, 4'h3);
    s_f;
    s_d;
    s_r;
    test_done;
  end
endmodule
